// ==== shared/scdt_map.svh ====
`ifndef SCDT_MAP_SVH
`define SCDT_MAP_SVH

// ==========================================
// Register offsets
`define SCDT_OFS_TRIM      8'h00
`define SCDT_OFS_DIV       8'h01
`define SCDT_OFS_STATUS    8'h02

// ==========================================
// Field layout of the divide control and status registers
`define SCDT_CE_BIT        7
`define SCDT_SEL_MSB       3
`define SCDT_SEL_LSB       0
`define SCDT_CE_ONLY       8'h80
`define SCDT_STAT_BUSY_BIT 4

// ==========================================
// Reset values and counts
`define SCDT_SEL_RST_PLAIN 4'h0
`define SCDT_SEL_RST_DIV8  4'h3
`define SCDT_SEL_MAX       4'h8
`define SCDT_CE_WINDOW     3'h4
`define SCDT_BOOT_CYC      2'h3
`define SCDT_CNT_ONES      8'hff

`endif

// ==== shared/scdt_pkg.sv ====
`include "scdt_map.svh"

package scdt_pkg;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h1,
        ST_WAIT_OLD = 3'h2,
        ST_WAIT_NEW = 3'h4
    } scdt_state_t;

    typedef struct packed {
        scdt_state_t state;
        logic [3:0]  act;
        logic [3:0]  sel;
        logic        ce;
        logic [2:0]  ce_cnt;
        logic [7:0]  trim;
        logic [7:0]  cnt;
        logic [1:0]  boot;
        logic        sys_en;
        logic        pin;
        logic        pin_oe;
        logic [7:0]  rdata;
    } scdt_regs_t;

endpackage

// ==== src/scdt_sync.sv ====
module scdt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk, // Source clock
    input  wire logic             rst,  // Async reset
    input  wire logic [WIDTH-1:0] d,    // Foreign level
    output logic      [WIDTH-1:0] q     // Synchronised level
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ==== src/scdt_top.sv ====
// Summary of operation
// [RQ1] Fuse programmed: system clock drives output pin
// [RQ2] Clock stays on pin during reset
// [RQ3] Pin carries the divided clock; held high at factor 1 instead
// [RQ4] One divided enable feeds all clock domains
// [RQ5] Division change is glitch free, no overspeed
// [RQ6] Switch: old period then new, two edges
// [RQ7] Counter runs on undivided clock, not readable
// [RQ8] Software: enable write, value within four cycles
// [RQ9] Enable bit set only with others zero
// [RQ10] Enable clears after four cycles or value write
// [RQ11] Rewriting enable neither restarts nor clears window
// [RQ12] Software keeps interrupts off during sequence
// [RQ13] Reset select: zero, or three with fuse
// [RQ14] Select field accepts any value at run time
// [RQ15] Select code n divides by two to n; codes above 8 divide by 256 instead
// [RQ16] Trim loads factory value at reset, writable
// [RQ17] Trim top bit picks overlapping frequency range
// [RQ18] Lower trim bits tune monotonically within range
// [RQ19] Software keeps oscillator below limit during writes
// [RQ20] Unused select bits read zero, ignore writes
module scdt_top (
    input  wire logic       mclk,                 // Undivided source clock
    input  wire logic       rst,                  // Async power-on reset
    input  wire logic [7:0] bus_addr,             // Register address
    input  wire logic [7:0] bus_wdata,            // Write data
    input  wire logic       bus_wr,               // Write strobe
    input  wire logic       bus_rd,               // Read strobe
    output logic      [7:0] bus_rdata,            // Read data, cycle after strobe
    input  wire logic       chip_reset,           // Chip reset level, async
    input  wire logic       clock_output_fuse,    // High when fuse programmed
    input  wire logic       divide_by_eight_fuse, // High when fuse programmed
    input  wire logic [7:0] factory_trim,         // Factory calibration value
    input  wire logic       port_pin_out,         // Ordinary port drive value
    input  wire logic       port_pin_oe,          // Ordinary port drive enable
    output logic            clock_output_pin_o,   // Output pin value
    output logic            clock_output_pin_oe,  // Output pin enable
    output logic            sys_clk_en,           // Divided clock enable, all domains
    output logic            trim_range_select,    // Oscillator range
    output logic      [6:0] trim_fine_value       // Oscillator fine tune
);
    // ==========================================
    // Input synchronisers
    logic       chip_reset_s;
    logic       clock_output_fuse_s;
    logic       div8_s;
    logic [7:0] factory_s;

    scdt_sync #(.WIDTH(11)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({chip_reset, clock_output_fuse, divide_by_eight_fuse, factory_trim}),
        .q    ({chip_reset_s, clock_output_fuse_s, div8_s, factory_s})
    );

    // ==========================================
    // State
    scdt_pkg::scdt_regs_t s_q;
    scdt_pkg::scdt_regs_t s_d;

    logic       load;
    logic       wr_div;
    logic       wr_ok;
    logic       tick;
    logic [3:0] n_eff;
    logic [7:0] mask;
    logic [3:0] load_sel;

    always_comb begin
        n_eff    = (s_q.act > `SCDT_SEL_MAX) ? `SCDT_SEL_MAX : s_q.act;
        mask     = ~(`SCDT_CNT_ONES << n_eff);                // [RQ15]
        tick     = ((s_q.cnt & mask) == mask);
        load     = (s_q.boot != 2'h0) || chip_reset_s;
        load_sel = div8_s ? `SCDT_SEL_RST_DIV8 : `SCDT_SEL_RST_PLAIN;
        wr_div   = bus_wr && !load && (bus_addr == `SCDT_OFS_DIV);
        wr_ok    = wr_div && s_q.ce && !bus_wdata[`SCDT_CE_BIT];
    end

    always_comb begin
        s_d        = s_q;
        s_d.rdata  = 8'h00;
        s_d.cnt    = s_q.cnt + 8'h01;                      // [RQ7]
        s_d.sys_en = tick;                                 // [RQ4]

        if (s_q.boot != 2'h0) begin
            s_d.boot = s_q.boot - 2'h1;
        end

        // Switch waits for an old edge, then runs a full new period
        unique case (s_q.state)
            scdt_pkg::ST_IDLE: begin
            end
            scdt_pkg::ST_WAIT_OLD: begin
                if (tick) begin                            // [RQ5] [RQ6]
                    s_d.act   = s_q.sel;
                    s_d.cnt   = 8'h00;
                    s_d.state = scdt_pkg::ST_WAIT_NEW;
                end
            end
            scdt_pkg::ST_WAIT_NEW: begin
                if (tick) begin                            // [RQ6]
                    s_d.state = scdt_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.state = scdt_pkg::ST_IDLE;
            end
        endcase

        // Change-enable window
        if (s_q.ce) begin
            s_d.ce_cnt = s_q.ce_cnt - 3'h1;
            if (s_q.ce_cnt == 3'h1) begin
                s_d.ce = 1'b0;                             // [RQ10]
            end
        end

        if (load) begin
            // Reset also switches glitch free, so the pin stays clean
            s_d.sel    = load_sel;                         // [RQ13]
            s_d.trim   = factory_s;                        // [RQ16]
            s_d.ce     = 1'b0;
            s_d.ce_cnt = 3'h0;
            if (s_q.act != load_sel || s_q.sel != load_sel) begin
                s_d.state = scdt_pkg::ST_WAIT_OLD;
            end
        end else if (bus_wr) begin
            if (bus_addr == `SCDT_OFS_TRIM) begin
                s_d.trim = bus_wdata;                      // [RQ16]
            end
            if (wr_div && bus_wdata == `SCDT_CE_ONLY && !s_q.ce) begin // [RQ11]
                s_d.ce     = 1'b1;                         // [RQ9]
                s_d.ce_cnt = `SCDT_CE_WINDOW;
            end
            if (wr_ok) begin
                // Upper bits 6..4 are dropped; reserved codes pass as written
                s_d.sel    = bus_wdata[`SCDT_SEL_MSB:`SCDT_SEL_LSB]; // [RQ14] [RQ20]
                s_d.ce     = 1'b0;                         // [RQ10]
                s_d.ce_cnt = 3'h0;
                s_d.state  = scdt_pkg::ST_WAIT_OLD;
            end
        end

        if (bus_rd) begin
            unique case (bus_addr)
                `SCDT_OFS_TRIM:   s_d.rdata = s_q.trim;
                `SCDT_OFS_DIV:    s_d.rdata = {s_q.ce, 3'h0, s_q.sel};  // [RQ20]
                `SCDT_OFS_STATUS: s_d.rdata = {3'h0, s_q.state != scdt_pkg::ST_IDLE, s_q.act};
                default:          s_d.rdata = 8'h00;
            endcase
        end

        // Pin shows counter bit n-1: a square wave at the divided rate.
        // At factor 1 a flop cannot carry the source clock; pin then holds high.
        if (n_eff == 4'h0) begin
            s_d.pin = 1'b1;                                // [RQ3]
        end else begin
            s_d.pin = s_d.cnt[3'(n_eff - 4'h1)];          // [RQ3]
        end
        if (!clock_output_fuse_s) begin
            s_d.pin = port_pin_out;
        end
        s_d.pin_oe = clock_output_fuse_s ? 1'b1 : port_pin_oe;         // [RQ1] [RQ2]
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q        <= '0;
            s_q.state  <= scdt_pkg::ST_IDLE;
            s_q.boot   <= `SCDT_BOOT_CYC;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    assign bus_rdata           = s_q.rdata;
    assign clock_output_pin_o  = s_q.pin;
    assign clock_output_pin_oe = s_q.pin_oe;
    assign sys_clk_en          = s_q.sys_en;
    assign trim_range_select   = s_q.trim[7];                  // [RQ17]
    assign trim_fine_value     = s_q.trim[6:0];                // [RQ18]

    // ==========================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence seq_ce_set;
        wr_div && !s_q.ce && bus_wdata == `SCDT_CE_ONLY && !load;
    endsequence

    sequence seq_val_write;
        wr_ok;
    endsequence

    chk_ce_timeout: assert property (seq_ce_set |=> s_q.ce ##[1:4] !s_q.ce) // [RQ10]
        else $error("change enable did not expire");

    chk_ce_no_restart: assert property (wr_div && s_q.ce && bus_wdata == `SCDT_CE_ONLY && !load // [RQ11]
        |=> s_q.ce_cnt == $past(s_q.ce_cnt) - 3'h1)
        else $error("change enable window restarted");

    chk_ce_clean_only: assert property (wr_div && !s_q.ce && bus_wdata != `SCDT_CE_ONLY // [RQ9]
        |=> !s_q.ce)
        else $error("change enable set by unclean write");

    chk_sel_ignored: assert property (wr_div && !s_q.ce && !chip_reset_s // [RQ10]
        |=> s_q.sel == $past(s_q.sel))
        else $error("select changed without enable");

    chk_sel_accept: assert property (seq_val_write // [RQ14]
        |=> s_q.sel == $past(bus_wdata[3:0]) && !s_q.ce && s_q.state == scdt_pkg::ST_WAIT_OLD)
        else $error("select write not taken");

    chk_pin_fuse: assert property (clock_output_fuse_s |=> clock_output_pin_oe) // [RQ2]
        else $error("clock pin not driven with fuse");

    chk_switch_two: assert property (s_q.state == scdt_pkg::ST_WAIT_OLD && tick && !load && !wr_ok // [RQ6]
        |=> s_q.act == $past(s_q.sel) && s_q.cnt == 8'h00 ##0 (s_q.state == scdt_pkg::ST_WAIT_NEW)[*1])
        else $error("switch did not follow old edge");

    chk_reset_sel: assert property (chip_reset_s |=> s_q.sel == ($past(div8_s) ? 4'h3 : 4'h0)) // [RQ13]
        else $error("select reset value wrong");

    chk_trim_load: assert property (chip_reset_s |=> s_q.trim == $past(factory_s)) // [RQ16]
        else $error("trim not loaded at reset");

    chk_half_rate: assert property (s_q.state == scdt_pkg::ST_IDLE && s_q.act == 4'h1 && tick // [RQ5]
        && $stable(s_q.act) ##1 s_q.state == scdt_pkg::ST_IDLE |-> !tick)
        else $error("divide by two edge spacing wrong");

    chk_div_read: assert property (bus_rd && bus_addr == `SCDT_OFS_DIV |=> bus_rdata[6:4] == 3'h0) // [RQ20]
        else $error("unused select bits not zero");

    // ==========================================
    // Pin checks
    chk_pin_port: assert property (!clock_output_fuse_s // [RQ1]
        |=> clock_output_pin_o == $past(port_pin_out)
            && clock_output_pin_oe == $past(port_pin_oe))
        else $error("port function not restored without fuse");

    chk_pin_undiv: assert property (clock_output_fuse_s && n_eff == 4'h0 // [RQ3]
        |=> clock_output_pin_o)
        else $error("pin not held high at factor one");

    // Factor two: the pin must follow the counter's lowest bit
    chk_pin_half: assert property (clock_output_fuse_s && s_q.act == 4'h1 && s_q.state == scdt_pkg::ST_IDLE // [RQ3]
        |=> clock_output_pin_o == s_q.cnt[0])
        else $error("pin not a square wave at factor two");

    // ==========================================
    // Divider checks
    sequence seq_new_tick;
        s_q.state == scdt_pkg::ST_WAIT_NEW && tick && !load && !wr_ok;
    endsequence

    chk_en_from_tick: assert property (tick // [RQ4]
        |=> sys_clk_en)
        else $error("divided enable missed a tick");

    chk_en_hold: assert property (!tick // [RQ4]
        |=> !sys_clk_en)
        else $error("divided enable without a tick");

    chk_en_undiv: assert property (s_q.act == 4'h0 // [RQ4] [RQ15]
        |=> sys_clk_en)
        else $error("enable not continuous at factor one");

    // Factor eight: seven quiet cycles, then the next tick
    chk_div8_gap: assert property (s_q.state == scdt_pkg::ST_IDLE && s_q.act == 4'h3 && tick // [RQ15]
        |=> (!tick)[*7] ##1 tick)
        else $error("factor eight tick spacing wrong");

    chk_cnt_runs: assert property (s_q.state != scdt_pkg::ST_WAIT_OLD // [RQ7]
        |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
        else $error("prescale counter stalled");

    // Outside a switch the active factor must not move
    chk_act_hold: assert property (s_q.state == scdt_pkg::ST_IDLE // [RQ5]
        |=> s_q.act == $past(s_q.act))
        else $error("active factor changed outside a switch");

    chk_old_wait: assert property (s_q.state == scdt_pkg::ST_WAIT_OLD && !tick && !load && !wr_ok // [RQ6]
        |=> s_q.state == scdt_pkg::ST_WAIT_OLD && s_q.act == $past(s_q.act))
        else $error("switch left before an old tick");

    chk_cnt_clear: assert property (s_q.state == scdt_pkg::ST_WAIT_OLD && tick // [RQ6]
        |=> s_q.cnt == 8'h00)
        else $error("counter not cleared at switch");

    chk_busy_end: assert property (seq_new_tick // [RQ6]
        |=> s_q.state == scdt_pkg::ST_IDLE)
        else $error("switch did not end on new tick");

    // ==========================================
    // Register checks
    chk_trim_write: assert property (bus_wr && bus_addr == `SCDT_OFS_TRIM && !load // [RQ17] [RQ18]
        |=> trim_range_select == $past(bus_wdata[7]) && trim_fine_value == $past(bus_wdata[6:0]))
        else $error("trim write not applied");

    chk_rd_trim: assert property (bus_rd && bus_addr == `SCDT_OFS_TRIM // [RQ16]
        |=> bus_rdata == $past(s_q.trim))
        else $error("trim read back wrong");

    chk_rd_enable: assert property (bus_rd && bus_addr == `SCDT_OFS_DIV // [RQ9]
        |=> bus_rdata[`SCDT_CE_BIT] == $past(s_q.ce))
        else $error("change enable read back wrong");

    // Status shows the active factor, never the count itself
    chk_rd_status: assert property (bus_rd && bus_addr == `SCDT_OFS_STATUS // [RQ7]
        |=> bus_rdata[7:5] == 3'h0 && bus_rdata[3:0] == $past(s_q.act))
        else $error("status read back wrong");

    chk_rdata_zero: assert property (!bus_rd // [RQ7]
        |=> bus_rdata == 8'h00)
        else $error("read data outside a read");

    // Boot load takes fuses only after they have passed the synchroniser
    chk_boot_sel: assert property (s_q.boot == 2'h1 // [RQ13]
        |=> s_q.sel == ($past(div8_s) ? `SCDT_SEL_RST_DIV8 : `SCDT_SEL_RST_PLAIN))
        else $error("select boot value wrong");

    chk_boot_trim: assert property (s_q.boot == 2'h1 // [RQ16]
        |=> s_q.trim == $past(factory_s))
        else $error("trim boot value wrong");

    chk_ce_arm: assert property (seq_ce_set // [RQ9]
        |=> s_q.ce && s_q.ce_cnt == `SCDT_CE_WINDOW)
        else $error("change enable window not armed");

    chk_ce_load: assert property (load // [RQ10]
        |=> !s_q.ce)
        else $error("change enable survived reset load");

    chk_ce_keep: assert property (wr_div && s_q.ce && s_q.ce_cnt > 3'h1 && bus_wdata == `SCDT_CE_ONLY // [RQ11]
        |=> s_q.ce)
        else $error("change enable cleared by rewrite");

endmodule

// ==== testbench/tb.sv ====
`include "scdt_map.svh"

`define CHK(name, exp, got) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("MISMATCH %s expected %0h seen %0h", name, exp, got); \
    end \
end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk                 = 1'b0;
    logic       rst                  = 1'b1;
    logic [7:0] bus_addr             = 8'h00;
    logic [7:0] bus_wdata            = 8'h00;
    logic       bus_wr               = 1'b0;
    logic       bus_rd               = 1'b0;
    logic       chip_reset           = 1'b0;
    logic       clock_output_fuse    = 1'b1;
    logic       divide_by_eight_fuse = 1'b1;
    logic [7:0] factory_trim         = 8'h5a;
    logic       port_pin_out         = 1'b0;
    logic       port_pin_oe          = 1'b1;
    logic [7:0] bus_rdata;
    logic       pin;
    logic       pin_oe;
    logic       clk_en;
    logic       range_sel;
    logic [6:0] fine;
    logic [7:0] d;
    int         failures             = 0;
    int         n_checks             = 0;
    int         cyc                  = 0;
    int         per;
    int         tog;
    int         mg;
    int         lst;

    scdt_top dut (
        .mclk                 (mclk),
        .rst                  (rst),
        .bus_addr             (bus_addr),
        .bus_wdata            (bus_wdata),
        .bus_wr               (bus_wr),
        .bus_rd               (bus_rd),
        .bus_rdata            (bus_rdata),
        .chip_reset           (chip_reset),
        .clock_output_fuse    (clock_output_fuse),
        .divide_by_eight_fuse (divide_by_eight_fuse),
        .factory_trim         (factory_trim),
        .port_pin_out         (port_pin_out),
        .port_pin_oe          (port_pin_oe),
        .clock_output_pin_o   (pin),
        .clock_output_pin_oe  (pin_oe),
        .sys_clk_en           (clk_en),
        .trim_range_select    (range_sel),
        .trim_fine_value      (fine)
    );

    // ==========================================
    // Clock, timeout and closing report
    always #12.5 mclk = ~mclk;

    // Ceiling: nine divider settings at about 810 to 1320 cycles each, plus margin
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================
    // Register bus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus_addr  <= a;
        bus_wdata <= v;
        bus_wr    <= 1'b1;
        @(posedge mclk);
        bus_wr    <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge mclk);
        bus_rd   <= 1'b0;
        @(negedge mclk);
        v = bus_rdata;
    endtask

    // Period of the divided enable and pin toggles within one period
    task automatic meas(output int p_out, output int t_out);
        int   k;
        logic p;
        k = 0;
        while (clk_en !== 1'b1 && k < 600) begin
            @(negedge mclk);
            k++;
        end
        p_out = 0;
        t_out = 0;
        p = pin;
        do begin
            @(negedge mclk);
            p_out++;
            if (pin !== p) t_out++;
            p = pin;
        end while (clk_en !== 1'b1 && p_out < 600);
    endtask

    // ==========================================
    // Test sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (20) @(posedge mclk);
        rd(`SCDT_OFS_DIV, d);  `CHK("div_reset", 8'h03, d)
        rd(`SCDT_OFS_TRIM, d); `CHK("trim_reset", 8'h5a, d)
        `CHK("range_reset", 1'b0, range_sel)
        `CHK("fine_reset", 7'h5a, fine)
        `CHK("pin_oe", 1'b1, pin_oe)
        rd(8'h10, d); `CHK("unmapped", 8'h00, d)
        wr(`SCDT_OFS_DIV, 8'h05);
        rd(`SCDT_OFS_DIV, d); `CHK("no_enable", 8'h03, d)
        wr(`SCDT_OFS_DIV, 8'h81);
        rd(`SCDT_OFS_DIV, d); `CHK("enable_dirty", 8'h03, d)
        wr(`SCDT_OFS_DIV, `SCDT_CE_ONLY);
        rd(`SCDT_OFS_DIV, d); `CHK("enable_open", 8'h83, d)
        @(posedge mclk);
        rd(`SCDT_OFS_DIV, d); `CHK("enable_timeout", 8'h03, d)
        wr(`SCDT_OFS_DIV, `SCDT_CE_ONLY);
        wr(`SCDT_OFS_DIV, `SCDT_CE_ONLY);
        @(posedge mclk);
        rd(`SCDT_OFS_DIV, d); `CHK("enable_rewrite", 8'h03, d)
        // Unused bits 6:4 set on purpose; they must read back as zero
        for (int n = 0; n <= 8; n++) begin
            wr(`SCDT_OFS_DIV, `SCDT_CE_ONLY);
            wr(`SCDT_OFS_DIV, 8'h70 | 8'(n));
            rd(`SCDT_OFS_DIV, d); `CHK("div_value", 8'(n), d)
            repeat (800) @(posedge mclk);
            rd(`SCDT_OFS_STATUS, d); `CHK("status", 8'(n), d)
            meas(per, tog);
            `CHK("period", 1 << n, per)
            `CHK("pin_toggles", (n == 0) ? 2'd0 : 2'd2, 2'(tog))
        end
        // Slow to fast: no gap may be shorter than the new period
        wr(`SCDT_OFS_DIV, `SCDT_CE_ONLY);
        wr(`SCDT_OFS_DIV, 8'h01);
        lst = -1;
        mg = 999;
        for (int k = 0; k < 600; k++) begin
            @(negedge mclk);
            if (clk_en === 1'b1) begin
                if (lst >= 0 && k - lst < mg) mg = k - lst;
                lst = k;
            end
        end
        `CHK("min_gap", 1'b1, mg >= 2)
        chip_reset <= 1'b1;
        repeat (10) @(posedge mclk);
        tog = 0;
        repeat (40) begin
            @(negedge mclk);
            if (pin !== d[0]) tog++;
            d[0] = pin;
        end
        `CHK("pin_oe_in_reset", 1'b1, pin_oe)
        `CHK("pin_runs_in_reset", 1'b1, tog > 2)
        @(posedge mclk);
        chip_reset <= 1'b0;
        repeat (20) @(posedge mclk);
        rd(`SCDT_OFS_DIV, d); `CHK("div_reload", 8'h03, d)
        wr(`SCDT_OFS_TRIM, 8'h80);
        repeat (2) @(negedge mclk);
        `CHK("range_high", 1'b1, range_sel)
        `CHK("fine_low", 7'h00, fine)
        wr(`SCDT_OFS_TRIM, 8'h7f);
        repeat (2) @(negedge mclk);
        `CHK("range_low", 1'b0, range_sel)
        `CHK("fine_high", 7'h7f, fine)
        rd(`SCDT_OFS_TRIM, d); `CHK("trim_rw", 8'h7f, d)
        tally_and_finish();
    end
endmodule
